// ### crf_core.sv
// programmer-visible register set, dma parameters and address map decode of the core
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "crf_defines.svh"

module crf_core #(
   parameter logic [23:0] RAM_END = `CRF_RAM_END_DEF
) (
   input  wire logic                core_clk_in,
   input  wire logic                rst_n_in,
   // classic wishbone slave
   input  wire logic                wb_cyc_in,
   input  wire logic                wb_stb_in,
   input  wire logic                wb_we_in,
   input  wire logic [7:0]          wb_adr_in,
   input  wire logic [3:0]          wb_sel_in,
   input  wire logic [31:0]         wb_dat_in,
   output logic      [31:0]         wb_dat_out,
   output logic                     wb_ack_out,
   // core side, same clock
   input  wire logic [23:0]         core_addr_in,
   input  wire logic                pc_load_in,
   input  wire logic [23:0]         pc_next_in,
   input  wire logic                fast_irq_take_in,
   input  wire logic                hw_irq_ack_in,
   input  wire logic                sw_int_in,
   input  wire logic [5:0]          sw_int_num_in,
   input  wire logic [1:0]          dma_reload_in,
   output logic                     bank_sel_out,
   output logic [23:0]              active_sp_out,
   output logic [23:0]              program_counter_out,
   output logic [23:0]              fast_vector_out,
   output logic [23:0]              vector_table_base_out,
   output crf_pkg::crf_region_t     region_out
);

   crf_pkg::crf_state_t s_q;
   crf_pkg::crf_state_t s_d;

   // byte-lane merge of a bus write into an old value
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  sel
   );
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            res[8*b +: 8] = new_val[8*b +: 8];
         end
      end
      return res;
   endfunction

   // map decode of a core address
   function automatic crf_pkg::crf_region_t decode_region(
      input logic [23:0] a
   );
      crf_pkg::crf_region_t r;
      r = crf_pkg::CRF_RGN_OTHER;
      if (a <= `CRF_PERIPH_END)
      begin
         r = crf_pkg::CRF_RGN_PERIPH;
      end
      else if (a >= `CRF_RAM_START && a <= RAM_END)
      begin
         r = crf_pkg::CRF_RGN_RAM;
      end
      else if (a >= `CRF_FIXVEC_START)
      begin
         r = crf_pkg::CRF_RGN_FIXVEC;
      end
      else if (a >= `CRF_SPAGE_START && a <= `CRF_SPAGE_END)
      begin
         r = crf_pkg::CRF_RGN_SPAGE;
      end
      return r;
   endfunction

   logic        access;
   logic        bank;
   logic        in_dma;
   logic        ch;
   logic [4:0]  dofs;
   logic [31:0] rd;
   logic [31:0] tmp;

   // all register behaviour: bus access first, core events after so they win
   always_comb
   begin
      s_d     = s_q;
      s_d.ack = 1'b0;
      rd      = 32'h0000_0000;
      tmp     = 32'h0000_0000;
      // one answer per request; ack drops the cycle after it was given
      access  = wb_cyc_in & wb_stb_in & ~s_q.ack;
      // bank decided by the flag as it stands before this edge
      bank    = s_q.flag[`CRF_FLG_BANK];
      in_dma  = wb_adr_in[7];
      ch      = wb_adr_in[5];
      dofs    = wb_adr_in[4:0];
      s_d.region = decode_region(core_addr_in);

      // read mux, unmapped words read zero
      if (!in_dma)
      begin
         case (wb_adr_in)
            `CRF_OFS_DATA0:     rd = {16'h0000, s_q.data[bank][0]};
            `CRF_OFS_DATA1:     rd = {16'h0000, s_q.data[bank][1]};
            `CRF_OFS_DATA2:     rd = {16'h0000, s_q.data[bank][2]};
            `CRF_OFS_DATA3:     rd = {16'h0000, s_q.data[bank][3]};
            `CRF_OFS_ADDR0:     rd = {8'h00, s_q.addr[bank][0]};
            `CRF_OFS_ADDR1:     rd = {8'h00, s_q.addr[bank][1]};
            `CRF_OFS_SB:        rd = {8'h00, s_q.sb[bank]};
            `CRF_OFS_FB:        rd = {8'h00, s_q.fb[bank]};
            `CRF_OFS_PC:        rd = {8'h00, s_q.pc};
            `CRF_OFS_VECTOR_TABLE_BASE:      rd = {8'h00, s_q.vector_table_base};
            `CRF_OFS_USP:       rd = {8'h00, s_q.user_stack_pointer};
            `CRF_OFS_ISP:       rd = {8'h00, s_q.interrupt_stack_pointer};
            `CRF_OFS_FLAG:      rd = {16'h0000, s_q.flag};
            `CRF_OFS_SVF:       rd = {16'h0000, s_q.saved_flags};
            `CRF_OFS_SVP:       rd = {8'h00, s_q.saved_program_counter};
            `CRF_OFS_VCT:       rd = {8'h00, s_q.fast_vector};
            `CRF_OFS_LONG_LOW:  rd = {s_q.data[bank][2], s_q.data[bank][0]};
            `CRF_OFS_LONG_HIGH: rd = {s_q.data[bank][3], s_q.data[bank][1]};
            `CRF_OFS_ACTIVE_SP: rd = {8'h00, s_q.active_sp};
            default:            rd = 32'h0000_0000;
         endcase
      end
      else if (wb_adr_in[6] == 1'b0)
      begin
         case (dofs)
            `CRF_DMA_MODE:      rd = {24'h00_0000, s_q.dma[ch].mode};
            `CRF_DMA_COUNT:     rd = {16'h0000, s_q.dma[ch].count};
            `CRF_DMA_COUNT_RLD: rd = {16'h0000, s_q.dma[ch].count_rld};
            `CRF_DMA_MEM:       rd = {8'h00, s_q.dma[ch].mem};
            `CRF_DMA_MEM_RLD:   rd = {8'h00, s_q.dma[ch].mem_rld};
            `CRF_DMA_FIXED:     rd = {8'h00, s_q.dma[ch].fixed};
            default:            rd = 32'h0000_0000;
         endcase
      end

      if (access)
      begin
         s_d.ack   = 1'b1;
         s_d.rdata = wb_we_in ? 32'h0000_0000 : rd;
      end
      else
      begin
         s_d.rdata = 32'h0000_0000;
      end

      // bus writes, merged per byte lane; narrow registers ignore upper lanes
      if (access && wb_we_in)
      begin
         tmp = lane_merge(rd, wb_dat_in, wb_sel_in);
         if (!in_dma)
         begin
            case (wb_adr_in)
               // lane 0 and lane 1 reach the low and high byte alone
               `CRF_OFS_DATA0:     s_d.data[bank][0] = tmp[15:0];
               `CRF_OFS_DATA1:     s_d.data[bank][1] = tmp[15:0];
               `CRF_OFS_DATA2:     s_d.data[bank][2] = tmp[15:0];
               `CRF_OFS_DATA3:     s_d.data[bank][3] = tmp[15:0];
               `CRF_OFS_ADDR0:     s_d.addr[bank][0] = tmp[23:0];
               `CRF_OFS_ADDR1:     s_d.addr[bank][1] = tmp[23:0];
               `CRF_OFS_SB:        s_d.sb[bank]      = tmp[23:0];
               `CRF_OFS_FB:        s_d.fb[bank]      = tmp[23:0];
               `CRF_OFS_PC:        s_d.pc            = tmp[23:0];
               `CRF_OFS_VECTOR_TABLE_BASE:      s_d.vector_table_base          = tmp[23:0];
               // odd stack values are kept; software is expected to use even ones
               `CRF_OFS_USP:       s_d.user_stack_pointer           = tmp[23:0];
               `CRF_OFS_ISP:       s_d.interrupt_stack_pointer           = tmp[23:0];
               // bank flips for all eight banked registers together
               `CRF_OFS_FLAG:      s_d.flag          = tmp[15:0];
               `CRF_OFS_SVF:       s_d.saved_flags           = tmp[15:0];
               `CRF_OFS_SVP:       s_d.saved_program_counter           = tmp[23:0];
               `CRF_OFS_VCT:       s_d.fast_vector           = tmp[23:0];
               `CRF_OFS_LONG_LOW:
               begin
                  s_d.data[bank][0] = tmp[15:0];
                  s_d.data[bank][2] = tmp[31:16];
               end
               `CRF_OFS_LONG_HIGH:
               begin
                  s_d.data[bank][1] = tmp[15:0];
                  s_d.data[bank][3] = tmp[31:16];
               end
               default:
               begin
                  s_d.data = s_d.data;                              // read-only or unmapped
               end
            endcase
         end
         else if (wb_adr_in[6] == 1'b0)
         begin
            case (dofs)
               `CRF_DMA_MODE:      s_d.dma[ch].mode      = tmp[7:0];
               `CRF_DMA_COUNT:     s_d.dma[ch].count     = tmp[15:0];
               `CRF_DMA_COUNT_RLD: s_d.dma[ch].count_rld = tmp[15:0];
               `CRF_DMA_MEM:       s_d.dma[ch].mem       = tmp[23:0];
               `CRF_DMA_MEM_RLD:   s_d.dma[ch].mem_rld   = tmp[23:0];
               `CRF_DMA_FIXED:     s_d.dma[ch].fixed     = tmp[23:0];
               default:
               begin
                  s_d.dma = s_d.dma;
               end
            endcase
         end
      end

      // per-channel reload from the core; hardware wins over a same-cycle write
      for (int c = 0; c < 2; c++)
      begin
         if (dma_reload_in[c])
         begin
            s_d.dma[c].count = s_q.dma[c].count_rld;
            s_d.dma[c].mem   = s_q.dma[c].mem_rld;
         end
      end

      // program counter advance by the core
      if (pc_load_in)
      begin
         s_d.pc = pc_next_in;
      end

      // fast interrupt: save flags and counter, branch to the fast vector
      if (fast_irq_take_in)
      begin
         s_d.saved_flags = s_q.flag;
         s_d.saved_program_counter = s_q.pc;
         s_d.pc  = s_q.fast_vector;
      end

      // interrupt entry forces the interrupt stack; beats a bus write of the flag
      if (hw_irq_ack_in || (sw_int_in && sw_int_num_in < `CRF_SWI_LIMIT))
      begin
         s_d.flag[`CRF_FLG_STACK] = 1'b0;
      end

      // registered copy of the active stack pointer, follows the new flag
      s_d.active_sp = s_d.flag[`CRF_FLG_STACK] ? s_d.user_stack_pointer : s_d.interrupt_stack_pointer;
   end

   // single state register
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s_q           <= '0;
         s_q.flag      <= `CRF_RST_FLAG;
         s_q.pc        <= `CRF_RST_WORD;
         s_q.active_sp <= `CRF_RST_WORD;
         s_q.region    <= crf_pkg::CRF_RGN_PERIPH;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign wb_dat_out            = s_q.rdata;
   assign wb_ack_out            = s_q.ack;
   assign bank_sel_out          = s_q.flag[`CRF_FLG_BANK];
   assign active_sp_out         = s_q.active_sp;
   assign program_counter_out   = s_q.pc;
   assign fast_vector_out       = s_q.fast_vector;
   assign vector_table_base_out = s_q.vector_table_base;
   assign region_out            = s_q.region;

endmodule // crf_core

// ### crf_defines.svh
// register offsets, field positions, reset values and map bounds of the core register file
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// bus offsets (byte addresses, one word each)
`define CRF_OFS_DATA0       8'h00
`define CRF_OFS_DATA1       8'h04
`define CRF_OFS_DATA2       8'h08
`define CRF_OFS_DATA3       8'h0C
`define CRF_OFS_ADDR0       8'h10
`define CRF_OFS_ADDR1       8'h14
`define CRF_OFS_SB          8'h18
`define CRF_OFS_FB          8'h1C
`define CRF_OFS_PC          8'h20
`define CRF_OFS_VECTOR_TABLE_BASE        8'h24
`define CRF_OFS_USP         8'h28
`define CRF_OFS_ISP         8'h2C
`define CRF_OFS_FLAG        8'h30
`define CRF_OFS_SVF         8'h34
`define CRF_OFS_SVP         8'h38
`define CRF_OFS_VCT         8'h3C
`define CRF_OFS_LONG_LOW    8'h40
`define CRF_OFS_LONG_HIGH   8'h44
`define CRF_OFS_ACTIVE_SP   8'h48
`define CRF_OFS_DMA_BASE    8'h80
// offsets inside one dma channel block, channel stride 0x20
`define CRF_DMA_MODE        5'h00
`define CRF_DMA_COUNT       5'h04
`define CRF_DMA_COUNT_RLD   5'h08
`define CRF_DMA_MEM         5'h0C
`define CRF_DMA_MEM_RLD     5'h10
`define CRF_DMA_FIXED       5'h14

// flag word fields and software interrupt number limit
`define CRF_FLG_BANK        4
`define CRF_FLG_STACK       7
`define CRF_SWI_LIMIT       6'h20

// reset values
`define CRF_RST_FLAG        16'h0000
`define CRF_RST_WORD        24'h00_0000

// address map bounds
`define CRF_PERIPH_END      24'h00_03FF
`define CRF_RAM_START       24'h00_0400
`define CRF_RAM_END_DEF     24'h00_2BFF
`define CRF_SPAGE_START     24'hFF_FE00
`define CRF_SPAGE_END       24'hFF_FFDB
`define CRF_FIXVEC_START    24'hFF_FFDC

`endif

// ### crf_pkg.sv
// types of the core register file
package crf_pkg;

   typedef enum logic [2:0] {
      CRF_RGN_PERIPH,
      CRF_RGN_RAM,
      CRF_RGN_SPAGE,
      CRF_RGN_FIXVEC,
      CRF_RGN_OTHER
   } crf_region_t;

   typedef struct packed {
      logic [7:0]  mode;
      logic [15:0] count;
      logic [15:0] count_rld;
      logic [23:0] mem;
      logic [23:0] mem_rld;
      logic [23:0] fixed;
   } crf_dma_t;

   typedef struct packed {
      logic [1:0][3:0][15:0] data;
      logic [1:0][1:0][23:0] addr;
      logic [1:0][23:0]      sb;
      logic [1:0][23:0]      fb;
      logic [23:0]           pc;
      logic [23:0]           vector_table_base;
      logic [23:0]           user_stack_pointer;
      logic [23:0]           interrupt_stack_pointer;
      logic [15:0]           flag;
      logic [15:0]           saved_flags;
      logic [23:0]           saved_program_counter;
      logic [23:0]           fast_vector;
      crf_dma_t [1:0]        dma;
      logic [23:0]           active_sp;
      crf_region_t           region;
      logic                  ack;
      logic [31:0]           rdata;
   } crf_state_t;

endpackage

// ### crf_monitor.sv
// concurrent checks on the ports of the core register file
`timescale 1ns/1ns
module crf_monitor #(
   parameter logic [23:0] RAM_END = 24'h00_2BFF
) (
   input wire logic                 core_clk_in,
   input wire logic                 rst_n_in,
   input wire logic                 wb_cyc_in,
   input wire logic                 wb_stb_in,
   input wire logic                 wb_we_in,
   input wire logic [7:0]           wb_adr_in,
   input wire logic [3:0]           wb_sel_in,
   input wire logic [31:0]          wb_dat_in,
   input wire logic                 wb_ack_out,
   input wire logic [23:0]          core_addr_in,
   input wire logic                 pc_load_in,
   input wire logic [23:0]          pc_next_in,
   input wire logic                 fast_irq_take_in,
   input wire logic                 bank_sel_out,
   input wire logic [23:0]          program_counter_out,
   input wire logic [23:0]          fast_vector_out,
   input wire logic [23:0]          vector_table_base_out,
   input wire crf_pkg::crf_region_t region_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic wr_take;
   // a write is taken only while ack is low, so a held strobe writes again only every other cycle
   assign wr_take = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out;
   periph_map_a:
      assert property (core_addr_in <= 24'h00_03FF |=> region_out == crf_pkg::CRF_RGN_PERIPH)
      else $error("peripheral area decode wrong");
   ram_map_a:
      assert property (core_addr_in >= 24'h00_0400 && core_addr_in <= RAM_END
         |=> region_out == crf_pkg::CRF_RGN_RAM) else $error("ram decode wrong");
   spage_map_a:
      assert property (core_addr_in inside {[24'hFF_FE00:24'hFF_FFDB]}
         |=> region_out == crf_pkg::CRF_RGN_SPAGE) else $error("special page decode wrong");
   fixvec_map_a:
      assert property (core_addr_in >= 24'hFF_FFDC |=> region_out == crf_pkg::CRF_RGN_FIXVEC)
      else $error("fixed vector decode wrong");
   pc_load_a:
      assert property (pc_load_in && !fast_irq_take_in
         |=> program_counter_out == $past(pc_next_in)) else $error("pc load lost");
   fast_jump_a:
      assert property (fast_irq_take_in |=> program_counter_out == $past(fast_vector_out))
      else $error("fast interrupt target wrong");
   bank_follow_a:
      assert property ($changed(bank_sel_out) |-> $past(wr_take && wb_adr_in == 8'h30
         && wb_sel_in[0]) && bank_sel_out == $past(wb_dat_in[4]))
      else $error("bank select moved without flag write");
   table_base_a:
      assert property ($changed(vector_table_base_out) |-> $past(wr_take && wb_adr_in == 8'h24))
      else $error("vector table base moved without write");
   ack_answer_a:
      assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("bus request not answered next cycle");
   ack_pulse_a:
      assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
endmodule // crf_monitor

// ### testbench.sv
// self-checking bench for the core register file
`timescale 1ns/1ns
`include "crf_defines.svh"
module testbench;
   logic clk, rst_n, cyc, stb, we, ack, pcl, fit, hwa, swi, bsel;
   logic [7:0] adr, a;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, v, w, m;
   logic [23:0] caddr, pcn, asp, pco, fvo, vtb, ca;
   logic [5:0] swn;
   logic [1:0] dmr;
   logic [15:0] lf;
   crf_pkg::crf_region_t rgn;
   int n_mismatch, tests_run, k;
   logic [23:0] cor [10] = '{24'h00_0000, 24'h00_03FF, 24'h00_0400, 24'h00_2BFF, 24'h00_2C00,
      24'hFF_FDFF, 24'hFF_FE00, 24'hFF_FFDB, 24'hFF_FFDC, 24'hFF_FFFF};
   crf_core crf_core_i (.core_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .core_addr_in(caddr), .pc_load_in(pcl), .pc_next_in(pcn),
      .fast_irq_take_in(fit), .hw_irq_ack_in(hwa), .sw_int_in(swi), .sw_int_num_in(swn),
      .dma_reload_in(dmr), .bank_sel_out(bsel), .active_sp_out(asp),
      .program_counter_out(pco), .fast_vector_out(fvo), .vector_table_base_out(vtb),
      .region_out(rgn));
   // free-running 100 MHz clock
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask
   // sixteen-bit shift register, two steps per word so runs repeat
   function automatic void rnd(output logic [31:0] r);
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      r[15:0] = lf;
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      r[31:16] = lf;
   endfunction
   // one classic cycle; the bound stands in for a slave that never answers
   task bus(input logic wr, input logic [7:0] ad, input logic [3:0] s, input logic [31:0] d,
      output logic [31:0] q);
      int i;
      @(posedge clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, wr, ad, s, d};
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (ack === 1'b1)
            break;
      end
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      if (i == 20)
      begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task wr_reg(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, ad, 4'hF, d, q);
   endtask
   task rd_chk(input logic [7:0] ad, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, ad, 4'hF, 32'h0000_0000, q);
      chk($sformatf("reg %h", ad), q, e);
   endtask
   function automatic logic [31:0] msk(input logic [7:0] ad);
      if (ad[7])
         return (ad[4:0] == 5'h00) ? 32'h0000_00FF :
            (ad[4:0] < 5'h0C) ? 32'h0000_FFFF : 32'h00FF_FFFF;
      return (ad < 8'h10 || ad == 8'h30 || ad == 8'h34) ? 32'h0000_FFFF : 32'h00FF_FFFF;
   endfunction
   function automatic crf_pkg::crf_region_t reg_of(input logic [23:0] x);
      if (x <= `CRF_PERIPH_END) return crf_pkg::CRF_RGN_PERIPH;
      if (x >= `CRF_RAM_START && x <= `CRF_RAM_END_DEF) return crf_pkg::CRF_RGN_RAM;
      if (x >= `CRF_FIXVEC_START) return crf_pkg::CRF_RGN_FIXVEC;
      if (x >= `CRF_SPAGE_START) return crf_pkg::CRF_RGN_SPAGE;
      return crf_pkg::CRF_RGN_OTHER;
   endfunction
   // main sequence
   initial
   begin
      {rst_n, cyc, stb, we, pcl, fit, hwa, swi, adr, sel, wdat, caddr, pcn, swn, dmr} = '0;
      lf = 16'h5870;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      // widths and zero reset of every plain register, flag left alone
      for (k = 0; k < 28; k++)
      begin
         a = (k < 16) ? 8'(k * 4) : 8'(128 + (k - 16) / 6 * 32 + (k - 16) % 6 * 4);
         if (a == 8'h30) continue;
         rd_chk(a, 32'h0000_0000);
         rnd(v);
         // stack pointers only ever get even values from software
         if (a == 8'h28 || a == 8'h2C)
            v[0] = 1'b0;
         wr_reg(a, v);
         rd_chk(a, v & msk(a));
         if (a == 8'h24)
            chk("table base out", {8'h00, vtb}, v & 32'h00FF_FFFF);
      end
      // byte lanes of the two split data registers
      for (a = 8'h00; a < 8'h08; a += 8'h04)
      begin
         wr_reg(a, 32'h0000_0000);
         bus(1'b1, a, 4'h2, 32'h0000_AB00, v);
         bus(1'b1, a, 4'h1, 32'h0000_FF12, v);
         rd_chk(a, 32'h0000_AB12);
      end
      rnd(v);
      wr_reg(8'h40, v);
      rd_chk(8'h08, {16'h0000, v[31:16]});
      rd_chk(8'h00, {16'h0000, v[15:0]});
      rnd(v);
      wr_reg(8'h0C, v);
      wr_reg(8'h04, {v[15:0], v[31:16]});
      rd_chk(8'h44, {v[15:0], v[31:16]});
      // both banks keep their own copy of all eight banked registers
      for (k = 0; k < 8; k++)
      begin
         a = 8'(k * 4);
         rnd(v);
         rnd(w);
         wr_reg(8'h30, 32'h0000_0000);
         wr_reg(a, v);
         wr_reg(8'h30, 32'h0000_0010);
         chk("bank select", {31'h0, bsel}, 32'h0000_0001);
         wr_reg(a, w);
         rd_chk(a, w & msk(a));
         wr_reg(8'h30, 32'h0000_0000);
         rd_chk(a, v & msk(a));
      end
      // stack choice and its clearing by interrupt events; active sp is read-only
      rnd(v);
      rnd(w);
      v[0] = 1'b0;
      w[0] = 1'b0;
      wr_reg(8'h28, v);
      wr_reg(8'h2C, w);
      wr_reg(8'h48, 32'h0000_1234);
      for (k = 0; k < 6; k++)
      begin
         wr_reg(8'h30, 32'h0000_0080);
         rd_chk(8'h48, v & 32'h00FF_FFFF);
         swn <= (k == 1) ? 6'd31 : (k == 2) ? 6'd32 : lf[5:0];
         hwa <= (k == 0);
         swi <= (k != 0);
         @(posedge clk);
         {hwa, swi} <= 2'b00;
         @(posedge clk);
         #1;
         m = (k == 0 || swn < 6'd32) ? w : v;
         chk("active sp", {8'h00, asp}, m & 32'h00FF_FFFF);
      end
      // fast interrupt saves flag and pc and wins over a same-edge pc load
      wr_reg(8'h30, 32'h0000_00A5);
      rnd(v);
      rnd(w);
      wr_reg(8'h20, v);
      wr_reg(8'h3C, w);
      @(posedge clk);
      {fit, pcl, pcn} <= {2'b11, ~v[23:0]};
      @(posedge clk);
      {fit, pcl} <= 2'b00;
      rd_chk(8'h34, 32'h0000_00A5);
      rd_chk(8'h38, v & 32'h00FF_FFFF);
      rd_chk(8'h20, w & 32'h00FF_FFFF);
      chk("fast vector out", {8'h00, fvo}, w & 32'h00FF_FFFF);
      rnd(v);
      @(posedge clk);
      {pcl, pcn} <= {1'b1, v[23:0]};
      @(posedge clk);
      pcl <= 1'b0;
      rd_chk(8'h20, v & 32'h00FF_FFFF);
      chk("pc out", {8'h00, pco}, v & 32'h00FF_FFFF);
      // dma reload restores count and memory address of one channel only
      for (k = 0; k < 2; k++)
      begin
         a = 8'(128 + k * 32);
         rnd(v);
         rnd(w);
         wr_reg(a + 8'h08, v);
         wr_reg(a + 8'h10, w);
         @(posedge clk);
         dmr <= 2'(1 << k);
         @(posedge clk);
         dmr <= 2'b00;
         rd_chk(a + 8'h04, v & 32'h0000_FFFF);
         rd_chk(a + 8'h0C, w & 32'h00FF_FFFF);
         if (k == 0)
            m = v;
      end
      // reload of channel one must leave channel zero alone
      rd_chk(8'h84, m & 32'h0000_FFFF);
      // unmapped places read zero and swallow writes
      wr_reg(8'h4C, 32'hFFFF_FFFF);
      rd_chk(8'h4C, 32'h0000_0000);
      wr_reg(8'hC0, 32'hFFFF_FFFF);
      rd_chk(8'hC0, 32'h0000_0000);
      // map decode on corners then random addresses biased to each region
      for (k = 0; k < 40; k++)
      begin
         rnd(v);
         ca = (k < 10) ? cor[k] : (k % 3 == 0) ? v[23:0] :
            (k % 3 == 1) ? {10'h000, v[13:0]} : {15'h7FFF, v[8:0]};
         @(posedge clk);
         caddr <= ca;
         @(posedge clk);
         #1;
         chk("region", 32'(rgn), 32'(reg_of(ca)));
      end
      stop_test();
   end
endmodule // testbench
bind crf_core crf_monitor #(.RAM_END(RAM_END)) crf_monitor_i (.*);
